// File: common/vscg_regs.vh
// Constants for the VRAM special cycle generator
`ifndef VSCG_REGS_VH
`define VSCG_REGS_VH
// ****************************************
// Register byte offsets
// ****************************************
`define VSCG_OFF_CTRL    12'h000
`define VSCG_OFF_PMASK   12'h004
`define VSCG_OFF_COLOR   12'h008
`define VSCG_OFF_CMD     12'h00C
`define VSCG_OFF_STATUS  12'h010
`define VSCG_OFF_ADDR    12'h014
`define VSCG_OFF_DATA    12'h018
`define VSCG_OFF_SCANLN  12'h01C
// ****************************************
// Control field positions
// ****************************************
`define VSCG_CTRL_FEAT   0
`define VSCG_CTRL_XPIX   1
`define VSCG_CTRL_VDIR   2
`define VSCG_CTRL_SPLT   3
`define VSCG_CTRL_WBEN   4
// ****************************************
// Operation codes written to the command register
// ****************************************
`define VSCG_OP_LDCOLOR  3'h1
`define VSCG_OP_BLKCOPY  3'h2
`define VSCG_OP_BLKFILL  3'h3
`define VSCG_OP_PIXWR    3'h4
`define VSCG_OP_PIXRD    3'h5
`define VSCG_OP_HBLANK   3'h6
// ****************************************
// Bus status codes
// ****************************************
`define VSCG_ST_LDCOLOR  4'h7
`define VSCG_ST_BLKWR    4'hE
`define VSCG_ST_MASKWR   4'hD
`define VSCG_ST_VIDXFER  4'h4
`define VSCG_ST_CPUXFER  4'h5
// ****************************************
// Reset values and timing
// ****************************************
`define VSCG_CTRL_RST    5'h00
`define VSCG_PHASE_CYC   3'h1
`endif

// File: rtl/vscg_top.v
// VRAM special cycle generator with APB register access
`timescale 1ns/100ps
`include "vscg_regs.vh"
module vscg_top (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        midline_match,
  input  wire        serial_shift_clock,
  input  wire        page_mode_ack,
  input  wire        half_width_bus_ack,
  input  wire        column_addr_mode,
  output reg         row_strobe_n,
  output reg         column_strobe_n,
  output reg         write_strobe_n,
  output reg         transfer_output_enable_n,
  output reg         special_function_pin,
  output reg  [31:0] local_addr_data_bus_o,
  output reg         local_addr_data_bus_oe
);
// ****************************************
// Cycle kinds and phase states
// ****************************************
localparam K_LDC  = 3'h0;
localparam K_BWU  = 3'h1;
localparam K_BWM  = 3'h2;
localparam K_MWR  = 3'h3;
localparam K_RDX  = 3'h4;
localparam K_SRX  = 3'h5;
localparam K_WRX  = 3'h6;
localparam K_AWX  = 3'h7;
localparam S_IDLE = 6'h01;
localparam S_ADDR = 6'h02;
localparam S_ROW  = 6'h04;
localparam S_COL  = 6'h08;
localparam S_SER  = 6'h10;
localparam S_END  = 6'h20;

reg  [4:0]  ctrl_r;
reg  [31:0] pmask_r;
reg  [31:0] color_r;
reg  [31:0] addr_r;
reg  [31:0] data_r;
reg  [2:0]  kind_r;
reg  [3:0]  stat_r;
reg  [5:0]  state_r;
reg  [2:0]  last_kind_r;
reg         busy_r;
reg         ser_q_r;
reg         mid_r;
reg  [2:0]  kind_nxt;
reg  [3:0]  stat_nxt;
reg         go_nxt;
reg         wstrobe_row;
reg         toe_row;
reg         sf_row;
reg         sf_col;
reg         mid_nxt;
wire        wr_en;
wire        rd_en;
wire [2:0]  op;
wire        mask_zero;
wire        ser_rise;

assign pready  = 1'b1;
assign pslverr = 1'b0;
assign wr_en   = psel & penable & pwrite;
assign rd_en   = psel & ~pwrite;
assign op      = pwdata[2:0];
assign mask_zero = (pmask_r == 32'h00000000);
// Edge from registered copy; idle level low matches reset value
assign ser_rise  = serial_shift_clock & ~ser_q_r;
// ****************************************
// Cycle selection; one kind per row period
// ****************************************
always @* begin
  go_nxt   = 1'b0;
  mid_nxt  = 1'b0;
  kind_nxt = K_LDC;
  stat_nxt = `VSCG_ST_LDCOLOR;
  if (wr_en && paddr == `VSCG_OFF_CMD && !busy_r) begin
    case (op)
      `VSCG_OP_LDCOLOR: begin
        go_nxt = 1'b1;
      end
      `VSCG_OP_BLKCOPY, `VSCG_OP_BLKFILL: begin
        go_nxt   = 1'b1;
        kind_nxt = mask_zero ? K_BWU : K_BWM;
        stat_nxt = `VSCG_ST_BLKWR;
      end
      `VSCG_OP_PIXWR: begin
        stat_nxt = `VSCG_ST_CPUXFER;
        if (ctrl_r[`VSCG_CTRL_XPIX]) begin
          go_nxt   = 1'b1;
          kind_nxt = K_AWX;
        end else if (!mask_zero && ctrl_r[`VSCG_CTRL_FEAT]) begin
          go_nxt   = 1'b1;
          kind_nxt = K_MWR;
          stat_nxt = `VSCG_ST_MASKWR;
        end
      end
      `VSCG_OP_PIXRD: begin
        if (ctrl_r[`VSCG_CTRL_XPIX]) begin
          go_nxt   = 1'b1;
          kind_nxt = K_RDX;
          stat_nxt = `VSCG_ST_CPUXFER;
        end
      end
      `VSCG_OP_HBLANK: begin
        stat_nxt = `VSCG_ST_VIDXFER;
        if (!ctrl_r[`VSCG_CTRL_VDIR]) begin
          go_nxt   = 1'b1;
          kind_nxt = K_RDX;
        end else if (ctrl_r[`VSCG_CTRL_WBEN]) begin
          go_nxt   = 1'b1;
          kind_nxt = K_WRX;
        end
      end
      default: go_nxt = 1'b0;
    endcase
  end else if (midline_match && !busy_r && !ctrl_r[`VSCG_CTRL_VDIR]) begin
    // Video request only taken when no command competes this cycle
    go_nxt   = 1'b1;
    // The request is a one-cycle pulse, so its source is remembered
    mid_nxt  = 1'b1;
    kind_nxt = ctrl_r[`VSCG_CTRL_SPLT] ? K_SRX : K_RDX;
    stat_nxt = `VSCG_ST_VIDXFER;
  end
end
// ****************************************
// Strobe levels at row and column fall per kind
// ****************************************
always @* begin
  wstrobe_row = 1'b1;
  toe_row     = 1'b1;
  sf_row      = 1'b1;
  sf_col      = 1'b1;
  case (kind_r)
    K_LDC: sf_col = 1'b1;
    K_BWU: sf_row = 1'b0;
    K_BWM: wstrobe_row = 1'b0;
    K_MWR: begin
      wstrobe_row = 1'b0;
      sf_col      = 1'b0;
    end
    K_RDX: begin
      toe_row = 1'b0;
      sf_row  = 1'b0;
    end
    K_SRX: toe_row = 1'b0;
    K_WRX: begin
      toe_row     = 1'b0;
      wstrobe_row = 1'b0;
      sf_row      = 1'b0;
    end
    K_AWX: begin
      toe_row     = 1'b0;
      wstrobe_row = 1'b0;
    end
    default: sf_col = 1'b1;
  endcase
end
// ****************************************
// APB registers
// ****************************************
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    ctrl_r  <= `VSCG_CTRL_RST;
    pmask_r <= 32'h00000000;
    color_r <= 32'h00000000;
    addr_r  <= 32'h00000000;
    data_r  <= 32'h00000000;
  end else if (wr_en) begin
    case (paddr)
      `VSCG_OFF_CTRL:  ctrl_r  <= pwdata[4:0];
      `VSCG_OFF_PMASK: pmask_r <= pwdata;
      `VSCG_OFF_COLOR: color_r <= pwdata;
      `VSCG_OFF_ADDR:  addr_r  <= pwdata;
      `VSCG_OFF_DATA:  data_r  <= pwdata;
      default:         ctrl_r  <= ctrl_r;
    endcase
  end
end

always @* begin
  case (paddr)
    `VSCG_OFF_CTRL:   prdata = {27'h0000000, ctrl_r};
    `VSCG_OFF_PMASK:  prdata = pmask_r;
    `VSCG_OFF_COLOR:  prdata = color_r;
    `VSCG_OFF_STATUS: prdata = {24'h000000, last_kind_r, stat_r, busy_r};
    `VSCG_OFF_ADDR:   prdata = addr_r;
    `VSCG_OFF_DATA:   prdata = data_r;
    default:          prdata = 32'h00000000;
  endcase
  if (!rd_en) prdata = 32'h00000000;
end
// ****************************************
// Cycle sequencer
// ****************************************
// Page-mode, half-width and column-mode inputs are deliberately unused here;
// the memory system keeps them at valid levels.
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    state_r                  <= S_IDLE;
    kind_r                   <= K_LDC;
    stat_r                   <= 4'h0;
    last_kind_r              <= 3'h0;
    busy_r                   <= 1'b0;
    ser_q_r                  <= 1'b0;
    mid_r                    <= 1'b0;
    row_strobe_n             <= 1'b1;
    column_strobe_n          <= 1'b1;
    write_strobe_n           <= 1'b1;
    transfer_output_enable_n <= 1'b1;
    special_function_pin     <= 1'b0;
    local_addr_data_bus_o    <= 32'h00000000;
    local_addr_data_bus_oe   <= 1'b0;
  end else begin
    ser_q_r <= serial_shift_clock;
    case (state_r)
      S_IDLE: begin
        if (go_nxt) begin
          kind_r  <= kind_nxt;
          stat_r  <= stat_nxt;
          busy_r  <= 1'b1;
          mid_r   <= mid_nxt;
          state_r <= S_ADDR;
          // Address phase: status code in the low four lines
          local_addr_data_bus_o  <= {addr_r[31:4], stat_nxt};
          local_addr_data_bus_oe <= 1'b1;
        end
      end
      S_ADDR: begin
        // Strobe levels set on the same edge as row fall
        write_strobe_n           <= wstrobe_row;
        transfer_output_enable_n <= toe_row;
        special_function_pin     <= sf_row;
        row_strobe_n             <= 1'b0;
        state_r                  <= S_ROW;
      end
      S_ROW: begin
        special_function_pin <= sf_col;
        write_strobe_n       <= (kind_r == K_LDC || kind_r == K_BWU) ? 1'b0 : write_strobe_n;
        case (kind_r)
          K_LDC: local_addr_data_bus_o <= color_r;
          K_BWU, K_BWM: local_addr_data_bus_o <= {28'h0000000, data_r[3:0]};
          K_MWR: local_addr_data_bus_o <= data_r;
          default: local_addr_data_bus_oe <= 1'b0;
        endcase
        state_r <= S_COL;
      end
      S_COL: begin
        column_strobe_n <= 1'b0;
        // Only a midline read transfer waits on the serial clock
        state_r         <= (kind_r == K_RDX && mid_r) ? S_SER : S_END;
      end
      S_SER: begin
        // Serial clock rise moves to S_END, which releases transfer enable next cycle
        if (ser_rise) state_r <= S_END;
      end
      S_END: begin
        row_strobe_n             <= 1'b1;
        column_strobe_n          <= 1'b1;
        write_strobe_n           <= 1'b1;
        transfer_output_enable_n <= 1'b1;
        special_function_pin     <= 1'b0;
        local_addr_data_bus_oe   <= 1'b0;
        last_kind_r              <= kind_r;
        busy_r                   <= 1'b0;
        state_r                  <= S_IDLE;
      end
      default: state_r <= S_IDLE;
    endcase
  end
end

endmodule // vscg_top

// File: sim/vscg_checker.sv
// Strobe and status checker for the special cycle generator
`timescale 1ns/100ps
`include "vscg_regs.vh"
module vscg_checker (
  input wire        pclk,
  input wire        presetn,
  input wire        serial_shift_clock,
  input wire        row_strobe_n,
  input wire        column_strobe_n,
  input wire        write_strobe_n,
  input wire        transfer_output_enable_n,
  input wire        special_function_pin,
  input wire [31:0] local_addr_data_bus_o,
  input wire        local_addr_data_bus_oe
);
  // ****************
  // Row fall and serial clock checks
  // ****************
  reg        rp_r;
  wire       we = write_strobe_n;
  wire       te = transfer_output_enable_n;
  wire       sf = special_function_pin;
  wire [3:0] st = local_addr_data_bus_o[3:0];
  wire       rf = rp_r & ~row_strobe_n;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) rp_r <= 1'h1;
    else rp_r <= row_strobe_n;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_load_color: assert property (rf && we && te && sf |->
    st == `VSCG_ST_LDCOLOR ##1 sf) else $error("bad load colour cycle");
  a_plain_block: assert property (rf && we && te && !sf |->
    st == `VSCG_ST_BLKWR ##1 sf) else $error("bad block write");
  a_masked_kinds: assert property (rf && !we && te && sf |->
    (st == `VSCG_ST_BLKWR || st == `VSCG_ST_MASKWR) ##1 sf == ($past(st) == `VSCG_ST_BLKWR))
    else $error("bad masked cycle");
  a_video_xfer: assert property (rf && !te && we == sf |->
    st == `VSCG_ST_VIDXFER) else $error("bad video transfer status");
  a_alt_write: assert property (rf && !te && !we && sf |->
    st == `VSCG_ST_CPUXFER) else $error("bad alternate write status");
  a_read_xfer: assert property (rf && !te && we && !sf |->
    (st == `VSCG_ST_VIDXFER || st == `VSCG_ST_CPUXFER) ##1 !local_addr_data_bus_oe)
    else $error("bad read transfer");
  a_column_fall: assert property (rf |-> ##1 column_strobe_n && !row_strobe_n
    ##1 !column_strobe_n) else $error("column strobe misplaced");
  a_cycle_end: assert property (rf |-> ##[3:40] row_strobe_n && column_strobe_n
    && !local_addr_data_bus_oe) else $error("cycle not released");
  a_serial_release: assert property ($rose(serial_shift_clock) && !column_strobe_n &&
    !transfer_output_enable_n |-> ##2 transfer_output_enable_n)
    else $error("transfer enable held after serial clock");
  c_xfer: cover property (rf && !te);
  c_masked: cover property (rf && !we && te);
  c_load: cover property (rf && we && te && sf);
endmodule // vscg_checker

// File: sim/vscg_top_test.sv
// Self-checking bench for the special cycle generator
`timescale 1ns/100ps
`include "vscg_regs.vh"
module vscg_top_test;
  // ****************
  // Bench
  // ****************
  localparam [31:0] LV = 32'h20A867DF;
  localparam [31:0] ST = 32'h5444DEE7;
  reg         pclk = 1'h0;
  reg         presetn = 1'h0;
  reg         psel = 1'h0;
  reg         penable = 1'h0;
  reg         pwrite = 1'h0;
  reg         midline_match = 1'h0;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h00000000;
  reg  [2:0]  ign = 3'h0;
  reg  [31:0] q, r;
  wire [31:0] prdata, local_addr_data_bus_o, row_bus, col_bus;
  wire [2:0]  row_lvl;
  wire [7:0]  row_cnt;
  wire        pready, pslverr, row_strobe_n, column_strobe_n, write_strobe_n;
  wire        transfer_output_enable_n, special_function_pin, local_addr_data_bus_oe;
  wire        serial_shift_clock, col_sf;
  integer     seed = 94489, error_cnt = 0, cmp_count = 0, n;
  vscg_top i_vscg_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .midline_match, .serial_shift_clock, .page_mode_ack(ign[0]),
    .half_width_bus_ack(ign[1]), .column_addr_mode(ign[2]), .row_strobe_n, .column_strobe_n,
    .write_strobe_n, .transfer_output_enable_n, .special_function_pin,
    .local_addr_data_bus_o, .local_addr_data_bus_oe);
  vscg_vram i_vscg_vram (.pclk, .row_strobe_n, .column_strobe_n, .write_strobe_n,
    .transfer_output_enable_n, .special_function_pin, .local_addr_data_bus_o,
    .local_addr_data_bus_oe, .serial_shift_clock, .row_lvl, .row_bus, .col_sf, .col_bus,
    .row_cnt);
  task stop_test;
    begin
      if (error_cnt == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  task hang;
    begin
      error_cnt = error_cnt + 1;
      stop_test;
    end
  endtask
  task chk(input [127:0] nm, input [31:0] e, input [31:0] g);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e) begin
        error_cnt = error_cnt + 1;
        $display("CHECK FAILED %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task xf(input w, input [11:0] a, input [31:0] d);
    integer t;
    begin
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      @(posedge pclk);
      for (t = 0; t < 20 && pready !== 1'h1; t = t + 1) @(posedge pclk);
      q = prdata;
      psel <= 1'h0;
      penable <= 1'h0;
      if (pready !== 1'h1) hang;
    end
  endtask
  function [3:0] kind(input [2:0] op, input [4:0] c, input [31:0] m, input mid);
    begin
      kind = 4'h8;
      if (mid) kind = c[`VSCG_CTRL_VDIR] ? 4'h8 : (c[`VSCG_CTRL_SPLT] ? 4'h5 : 4'h4);
      else case (op)
        `VSCG_OP_LDCOLOR: kind = 4'h0;
        `VSCG_OP_BLKCOPY, `VSCG_OP_BLKFILL: kind = (m == 0) ? 4'h1 : 4'h2;
        `VSCG_OP_PIXWR: kind = c[`VSCG_CTRL_XPIX] ? 4'h7 : ((c[0] && m != 0) ? 4'h3 : 4'h8);
        `VSCG_OP_PIXRD: kind = c[`VSCG_CTRL_XPIX] ? 4'h4 : 4'h8;
        `VSCG_OP_HBLANK: kind = !c[`VSCG_CTRL_VDIR] ? 4'h4 : (c[`VSCG_CTRL_WBEN] ? 4'h6 : 4'h8);
        default: kind = 4'h8;
      endcase
    end
  endfunction
  task run(input [2:0] op, input mid, input [4:0] c, input [31:0] m);
    reg [3:0]  k, s;
    reg [31:0] col, adr, dat;
    integer    t, b;
    begin
      k = kind(op, c, m, mid);
      col = $random(seed);
      adr = $random(seed);
      dat = $random(seed);
      r = $random(seed);
      ign <= r[2:0];
      s = (k == 4'h4 && !mid && op == `VSCG_OP_PIXRD) ? `VSCG_ST_CPUXFER : ST[k * 4 +: 4];
      if (k != 4'h8) begin
        xf(1'h1, `VSCG_OFF_CTRL, {27'h0, c});
        xf(1'h1, `VSCG_OFF_PMASK, m);
        xf(1'h1, `VSCG_OFF_COLOR, col);
        xf(1'h1, `VSCG_OFF_ADDR, adr);
        xf(1'h1, `VSCG_OFF_DATA, dat);
        b = row_cnt;
        if (mid) begin
          @(posedge pclk);
          midline_match <= 1'h1;
          @(posedge pclk);
          midline_match <= 1'h0;
        end else begin
          xf(1'h1, `VSCG_OFF_CMD, {29'h0, op});
          // Second command lands while busy and must be dropped
          xf(1'h1, `VSCG_OFF_CMD, {29'h0, `VSCG_OP_LDCOLOR});
        end
        q = 32'h00000001;
        for (t = 0; t < 40 && q[0] !== 1'h0; t = t + 1) xf(1'h0, `VSCG_OFF_STATUS, 32'h0);
        if (q[0] !== 1'h0) hang;
        chk("row count", b + 1, row_cnt);
        chk("status reg", {k[2:0], s}, q[7:1]);
        chk("row levels", LV[k * 4 + 1 +: 3], row_lvl);
        chk("addr phase", {adr[31:4], s}, row_bus);
        if (k < 4'h4) chk("column sf", LV[k * 4], col_sf);
        if (k == 4'h0) chk("colour", col, col_bus);
        if (k == 4'h1 || k == 4'h2) chk("column mask", dat[3:0], col_bus[3:0]);
        if (k == 4'h3) chk("masked data", dat, col_bus);
      end
    end
  endtask
  initial begin
    forever #5 pclk = ~pclk;
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    xf(1'h0, `VSCG_OFF_CTRL, 32'h0);
    chk("ctrl reset", {27'h0, `VSCG_CTRL_RST}, q);
    xf(1'h0, 12'hFFC, 32'h0);
    chk("unmapped read", 32'h0, q);
    run(`VSCG_OP_BLKFILL, 1'h0, 5'h01, 32'h80000000);
    run(`VSCG_OP_PIXWR, 1'h0, 5'h01, 32'h00000001);
    run(`VSCG_OP_HBLANK, 1'h0, 5'h14, 32'h0);
    run(3'h0, 1'h1, 5'h08, 32'h0);
    for (n = 0; n < 150; n = n + 1) begin
      r = $random(seed);
      run(r[2:0], r[2:0] == 3'h0, r[7:3], r[8] ? 32'h0 : $random(seed));
    end
    stop_test;
  end
endmodule // vscg_top_test
bind vscg_top vscg_checker i_vscg_checker (.pclk, .presetn, .row_strobe_n, .column_strobe_n,
  .write_strobe_n, .transfer_output_enable_n, .special_function_pin,
  .local_addr_data_bus_o, .local_addr_data_bus_oe, .serial_shift_clock);

// File: sim/vscg_vram.sv
// Behavioural video RAM array seen from the local bus
`timescale 1ns/100ps
module vscg_vram (
  input  wire        pclk,
  input  wire        row_strobe_n,
  input  wire        column_strobe_n,
  input  wire        write_strobe_n,
  input  wire        transfer_output_enable_n,
  input  wire        special_function_pin,
  input  wire [31:0] local_addr_data_bus_o,
  input  wire        local_addr_data_bus_oe,
  output wire        serial_shift_clock,
  output reg  [2:0]  row_lvl,
  output reg  [31:0] row_bus,
  output reg         col_sf,
  output reg  [31:0] col_bus,
  output reg  [7:0]  row_cnt = 8'h00
);
  // ****************
  // Strobe capture
  // ****************
  reg       rp_r = 1'h1;
  reg       cp_r = 1'h1;
  reg [1:0] sc_r = 2'h0;
  // Serial clock stands still outside transfers
  assign serial_shift_clock = sc_r[1];
  // No serial enable pin or half-bus mux modelled here
  always @(posedge pclk) begin
    rp_r <= row_strobe_n;
    cp_r <= column_strobe_n;
    sc_r <= (!row_strobe_n && !transfer_output_enable_n) ? sc_r + 2'h1 : 2'h0;
    if (rp_r && !row_strobe_n) begin
      row_lvl <= {write_strobe_n, transfer_output_enable_n, special_function_pin};
      // Undriven bus reads inverted so stale data never matches
      row_bus <= local_addr_data_bus_oe ? local_addr_data_bus_o : ~row_bus;
      row_cnt <= row_cnt + 8'h01;
    end
    if (cp_r && !column_strobe_n) begin
      col_sf <= special_function_pin;
      col_bus <= local_addr_data_bus_oe ? local_addr_data_bus_o : ~col_bus;
    end
  end
endmodule // vscg_vram
